// *** hdl/pieb_pkg.sv ***
// package: register map, field positions and bus types for the enable bank
package pieb_pkg;
    // register byte addresses on the ahb-lite slave
    localparam logic [7:0] PIEB_OFS_ENABLE_1 = 8'h00;
    localparam logic [7:0] PIEB_OFS_ENABLE_2 = 8'h04;
    localparam logic [7:0] PIEB_OFS_ENABLE_3 = 8'h08;
    localparam logic [7:0] PIEB_OFS_CONTROL = 8'h0C;
    localparam logic [7:0] PIEB_OFS_STATUS = 8'h10;
    localparam logic [7:0] PIEB_OFS_MASK = 8'h14;
    localparam logic [7:0] PIEB_OFS_REQ = 8'h18;
    // implemented-bit masks of the three enable registers
    localparam logic [7:0] PIEB_IMPL_1 = 8'h7F;
    localparam logic [7:0] PIEB_IMPL_2 = 8'h95;
    localparam logic [7:0] PIEB_IMPL_3 = 8'h1F;
    // reset value of every enable register
    localparam logic [7:0] PIEB_ENABLE_RST = 8'h00;
    // first register field positions
    localparam int PIEB_B1_CONVERTER = 6;
    localparam int PIEB_B1_SERIAL_RX = 5;
    localparam int PIEB_B1_SERIAL_TX = 4;
    localparam int PIEB_B1_SYNC_SERIAL = 3;
    localparam int PIEB_B1_CAPCOMP_ONE = 2;
    localparam int PIEB_B1_TIMER_TWO = 1;
    localparam int PIEB_B1_TIMER_ONE = 0;
    // second register field positions
    localparam int PIEB_B2_OSC_FAIL = 7;
    localparam int PIEB_B2_EEPROM = 4;
    localparam int PIEB_B2_LOW_VOLTAGE = 2;
    localparam int PIEB_B2_CAPCOMP_TWO = 0;
    // control register fields
    localparam int PIEB_CTL_GLOBAL = 0;
    localparam int PIEB_CTL_PRIO = 1;
    localparam logic [1:0] PIEB_CTL_RST = 2'h0;
    // status register fields: request rise and fall events
    localparam int PIEB_ST_RISE = 0;
    localparam int PIEB_ST_FALL = 1;
    localparam logic [1:0] PIEB_ST_RST = 2'h0;
    // ahb transfer types and read-data reset value
    localparam logic [1:0] PIEB_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] PIEB_HTRANS_SEQ = 2'h3;
    localparam logic [31:0] PIEB_RDATA_RST = 32'h0000_0000;
    // ahb-lite address phase bundle
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } pieb_ahb_req_t;
    // ahb-lite slave answer bundle
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } pieb_ahb_rsp_t;
    // per-source request flags, one byte per enable register
    typedef struct packed {
        logic [7:0] bank3;
        logic [7:0] bank2;
        logic [7:0] bank1;
    } pieb_flags_t;
endpackage

// *** hdl/pieb_gate.sv ***
// per-source and gated request forming for the enable bank
`timescale 1ns/1ns
`default_nettype none
module pieb_gate
    import pieb_pkg::*;
(
    input wire pieb_pkg::pieb_flags_t flags,
    input wire pieb_pkg::pieb_flags_t enables,
    input wire logic global_periph_irq_enable,
    input wire logic irq_priority_mode_enable,
    output logic [23:0] gated,
    output logic any_req
);
    // flat views of flags and enables
    wire [23:0] flag_vec = flags;
    wire [23:0] en_vec = enables;
    // global gate applies only in non-priority mode
    wire global_ok;

    genvar gi;
    generate
        for (gi = 0; gi < 24; gi++)
        begin : g_src
            assign gated[gi] = flag_vec[gi] & en_vec[gi];
        end
    endgenerate

    assign global_ok = irq_priority_mode_enable | global_periph_irq_enable;
    assign any_req = (|gated) & global_ok;
endmodule
`default_nettype wire

// *** hdl/pieb_ahb.sv ***
// ahb-lite slave front end: address-phase capture for the enable bank
`timescale 1ns/1ns
`default_nettype none
module pieb_ahb
    import pieb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire pieb_pkg::pieb_ahb_req_t req,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr
);
    // a transfer is taken when selected, active and bus ready
    wire take = req.hsel & req.hready
        & ((req.htrans == PIEB_HTRANS_NONSEQ) | (req.htrans == PIEB_HTRANS_SEQ));
    logic wr_r;
    logic rd_r;
    logic [7:0] addr_r;

    // register the address phase for use in the data phase
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= 8'h00;
        end
        else
        begin
            wr_r <= take & req.hwrite;
            rd_r <= take & ~req.hwrite;
            if (take)
                addr_r <= req.haddr[7:0];
        end
    end
    assign wr_en = wr_r;
    assign rd_en = rd_r;
    assign addr = addr_r;
endmodule
`default_nettype wire

// *** hdl/pieb_top.sv ***
// peripheral interrupt enable bank with ahb-lite registers
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - non-priority mode needs global enable set for periph_irq_req; periph_irq_gated ignores it
// - three enable registers, one bit per source
// - first register bits six down to zero
// - enable one passes, zero blocks the request
// - second register bits seven, four, two, zero
// - unimplemented enable bits read as zero
// - enables reset to zero, then read-write
module pieb_top
    import pieb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire pieb_pkg::pieb_ahb_req_t ahb_req,
    input wire logic [31:0] hwdata,
    output pieb_pkg::pieb_ahb_rsp_t ahb_rsp,
    input wire pieb_pkg::pieb_flags_t src_flags,
    output logic periph_irq_req,
    output logic [23:0] periph_irq_gated,
    output logic irq
);
    import pieb_pkg::*;

    // data phase strobes from the bus front end
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    // enable registers, one byte each
    logic [7:0] periph_irq_enable_1_r;
    logic [7:0] periph_irq_enable_2_r;
    logic [7:0] periph_irq_enable_3_r;
    // control: global enable and priority mode
    logic [1:0] ctl_r;
    // sticky event status, mask
    logic [1:0] status_r;
    logic [1:0] status_nxt;
    logic [1:0] mask_r;
    // previous combined request, for edge events
    logic req_prev_r;
    logic [31:0] rdata_r;
    // combinational results
    logic any_req;
    logic [23:0] gated;

    pieb_ahb u_ahb (
        .clk(clk),
        .rst(rst),
        .req(ahb_req),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .addr(addr)
    );

    // enables packed for the gate
    // bank three sits on top so gated bits line up with the flag struct
    wire pieb_flags_t enables = {periph_irq_enable_3_r,
        periph_irq_enable_2_r, periph_irq_enable_1_r};
    wire global_periph_irq_enable = ctl_r[PIEB_CTL_GLOBAL];
    wire irq_priority_mode_enable = ctl_r[PIEB_CTL_PRIO];

    pieb_gate u_gate (
        .flags(src_flags),
        .enables(enables),
        .global_periph_irq_enable(global_periph_irq_enable),
        .irq_priority_mode_enable(irq_priority_mode_enable),
        .gated(gated),
        .any_req(any_req)
    );

    // address decode, data phase
    wire sel_en1 = (addr == PIEB_OFS_ENABLE_1);
    wire sel_en2 = (addr == PIEB_OFS_ENABLE_2);
    wire sel_en3 = (addr == PIEB_OFS_ENABLE_3);
    wire sel_ctl = (addr == PIEB_OFS_CONTROL);
    wire sel_st = (addr == PIEB_OFS_STATUS);
    wire sel_mask = (addr == PIEB_OFS_MASK);
    wire sel_req = (addr == PIEB_OFS_REQ);

    // named bits of the first and second registers
    wire converter_done_enable = periph_irq_enable_1_r[PIEB_B1_CONVERTER];
    wire serial_rx_enable = periph_irq_enable_1_r[PIEB_B1_SERIAL_RX];
    wire osc_fail_enable = periph_irq_enable_2_r[PIEB_B2_OSC_FAIL];
    wire low_voltage_enable = periph_irq_enable_2_r[PIEB_B2_LOW_VOLTAGE];

    // read-data selection; unmapped words read as zero
    logic [31:0] rdata_sel;
    always_comb
    begin
        rdata_sel = 32'h0000_0000;
        if (sel_en1)
            rdata_sel = {24'h000000, periph_irq_enable_1_r};
        else if (sel_en2)
            rdata_sel = {24'h000000, periph_irq_enable_2_r};
        else if (sel_en3)
            rdata_sel = {24'h000000, periph_irq_enable_3_r};
        else if (sel_ctl)
            rdata_sel = {30'h0, ctl_r};
        else if (sel_st)
            rdata_sel = {30'h0, status_r};
        else if (sel_mask)
            rdata_sel = {30'h0, mask_r};
        else if (sel_req)
            rdata_sel = {31'h0, any_req};
    end

    // three enable registers written by software
    // first register keeps bits six to zero
    // second register keeps bits seven, four, two, zero
    // unimplemented bits never store, so read zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            periph_irq_enable_1_r <= PIEB_ENABLE_RST;
            periph_irq_enable_2_r <= PIEB_ENABLE_RST;
            periph_irq_enable_3_r <= PIEB_ENABLE_RST;
        end
        else if (wr_en)
        begin
            if (sel_en1)
                periph_irq_enable_1_r <= hwdata[7:0] & PIEB_IMPL_1;
            if (sel_en2)
                periph_irq_enable_2_r <= hwdata[7:0] & PIEB_IMPL_2;
            if (sel_en3)
                periph_irq_enable_3_r <= hwdata[7:0] & PIEB_IMPL_3;
        end
    end

    // control and mask registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctl_r <= PIEB_CTL_RST;
            mask_r <= PIEB_ST_RST;
        end
        else if (wr_en)
        begin
            if (sel_ctl)
                ctl_r <= hwdata[1:0];
            if (sel_mask)
                mask_r <= hwdata[1:0];
        end
    end

    // sticky events; a new event wins over a write-one clear
    // only ones in the write data clear, so writing zero is harmless
    wire ev_rise = any_req & ~req_prev_r;
    wire ev_fall = ~any_req & req_prev_r;
    wire [1:0] clr = (wr_en & sel_st) ? hwdata[1:0] : 2'h0;
    always_comb
    begin
        status_nxt = status_r & ~clr;
        status_nxt[PIEB_ST_RISE] = status_nxt[PIEB_ST_RISE] | ev_rise;
        status_nxt[PIEB_ST_FALL] = status_nxt[PIEB_ST_FALL] | ev_fall;
    end

    // status and edge history
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_r <= PIEB_ST_RST;
            req_prev_r <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            req_prev_r <= any_req;
        end
    end

    // read data latched at the data phase
    // keeping the last word holds hrdata steady between reads
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_r <= PIEB_RDATA_RST;
        else if (rd_en)
            rdata_r <= rdata_sel;
    end

    // zero wait states in this design: the answer is ready at once,
    // so hrdata must be combinational in the data phase
    assign ahb_rsp.hrdata = rd_en ? rdata_sel : rdata_r;
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp = 1'b0;

    // one combined request to the core
    assign periph_irq_req = any_req;
    assign periph_irq_gated = gated;
    assign irq = |(status_r & mask_r);

    // no request while global off in non-priority mode
    a_global_gate: assert property (@(posedge clk) disable iff (rst)
        (!irq_priority_mode_enable && !global_periph_irq_enable)
        |-> !periph_irq_req)
        else $error("request forwarded with global enable clear");

    a_block_conv: assert property (@(posedge clk) disable iff (rst)
        !converter_done_enable |-> !periph_irq_gated[PIEB_B1_CONVERTER])
        else $error("converter request passed while disabled");

    a_pass_rx: assert property (@(posedge clk) disable iff (rst)
        (serial_rx_enable && src_flags.bank1[PIEB_B1_SERIAL_RX])
        |-> periph_irq_gated[PIEB_B1_SERIAL_RX])
        else $error("enabled serial receive request blocked");

    a_unimpl_zero: assert property (@(posedge clk) disable iff (rst)
        ((periph_irq_enable_1_r & ~PIEB_IMPL_1) == 8'h00)
        && ((periph_irq_enable_2_r & ~PIEB_IMPL_2) == 8'h00))
        else $error("unimplemented enable bit set");

    a_write_en2: assert property (@(posedge clk) disable iff (rst)
        (wr_en && sel_en2) |=> (periph_irq_enable_2_r
        == ($past(hwdata[7:0]) & PIEB_IMPL_2)))
        else $error("second enable register not written");

    a_reset_zero: assert property (@(posedge clk)
        $past(rst) |-> (periph_irq_enable_1_r == 8'h00)
        && (periph_irq_enable_2_r == 8'h00))
        else $error("enable not cleared by reset");

    // combined request matches gated bits in priority mode
    a_combine: assert property (@(posedge clk) disable iff (rst)
        irq_priority_mode_enable |-> (periph_irq_req == (|periph_irq_gated)))
        else $error("combined request mismatch");

    // oscillator fail bit gates its source
    a_osc_fail: assert property (@(posedge clk) disable iff (rst)
        periph_irq_gated[8 + PIEB_B2_OSC_FAIL]
        |-> osc_fail_enable && src_flags.bank2[PIEB_B2_OSC_FAIL])
        else $error("oscillator fail gating wrong");

    a_lv_block: assert property (@(posedge clk) disable iff (rst)
        !low_voltage_enable ##1 !low_voltage_enable
        |-> !periph_irq_gated[8 + PIEB_B2_LOW_VOLTAGE])
        else $error("low voltage request passed while disabled");

    // first register takes the written implemented bits
    a_write_en1: assert property (@(posedge clk) disable iff (rst)
        (wr_en && sel_en1) |=> (periph_irq_enable_1_r
        == ($past(hwdata[7:0]) & PIEB_IMPL_1)))
        else $error("first enable register not written");

    // third register takes the written implemented bits
    a_write_en3: assert property (@(posedge clk) disable iff (rst)
        (wr_en && sel_en3) |=> (periph_irq_enable_3_r
        == ($past(hwdata[7:0]) & PIEB_IMPL_3)))
        else $error("third enable register not written");

    // enables hold while no write lands
    a_hold_en: assert property (@(posedge clk) disable iff (rst)
        !wr_en |=> $stable(periph_irq_enable_1_r)
        && $stable(periph_irq_enable_2_r)
        && $stable(periph_irq_enable_3_r))
        else $error("enable register changed without a write");

    // global enable lets the combined request through
    a_global_pass: assert property (@(posedge clk) disable iff (rst)
        global_periph_irq_enable
        |-> (periph_irq_req == (|periph_irq_gated)))
        else $error("request lost with global enable set");

    a_write_ctl: assert property (@(posedge clk) disable iff (rst)
        (wr_en && sel_ctl) |=> (ctl_r == $past(hwdata[1:0])))
        else $error("control register not written");

    // a rise of the combined request is recorded
    a_rise_sticky: assert property (@(posedge clk) disable iff (rst)
        (periph_irq_req && !req_prev_r) |=> status_r[PIEB_ST_RISE])
        else $error("request rise not recorded");

    // a fall of the combined request is recorded
    a_fall_sticky: assert property (@(posedge clk) disable iff (rst)
        (!periph_irq_req && req_prev_r) |=> status_r[PIEB_ST_FALL])
        else $error("request fall not recorded");

    // enable reads carry no upper bits
    a_read_upper: assert property (@(posedge clk) disable iff (rst)
        (rd_en && (sel_en1 || sel_en2 || sel_en3))
        |-> (ahb_rsp.hrdata[31:8] == 24'h000000))
        else $error("enable read shows upper bits");
endmodule
`default_nettype wire

// *** bench/pieb_src_model.sv ***
// behavioural peripheral flag sources feeding the enable bank
`timescale 1ns/1ns
`default_nettype none
module pieb_src_model
    import pieb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire pieb_pkg::pieb_flags_t set,
    input wire pieb_pkg::pieb_flags_t clr,
    output var pieb_pkg::pieb_flags_t flags
);
    // sticky flags: an event sets a bit and only a clear drops it,
    // so a masked source keeps its record until software acts
    // flag keeps event
    always_ff @(posedge clk)
    begin
        if (rst)
            flags <= '0;
        else
            flags <= (flags | set) & ~clr;
    end
endmodule
`default_nettype wire

// *** bench/peripheral_interrupt_enable_bank_tb.sv ***
// self-checking bench for the enable bank over ahb-lite
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module peripheral_interrupt_enable_bank_tb;
    import pieb_pkg::*;
    logic clk; // bench clock
    logic rst; // sync reset, high
    pieb_ahb_req_t req; // master address phase
    pieb_ahb_req_t ar; // address phase with bus hready folded in
    pieb_ahb_rsp_t rsp; // slave answer
    logic [31:0] hwdata; // write data
    pieb_flags_t fset, fclr, flags; // flag model controls
    logic preq, irq; // combined request and event irq
    logic [23:0] gated; // per-source gated requests
    logic [31:0] rd_s; // read data sampled in data phase
    logic rdy; // sampled hreadyout
    logic [7:0] e1, e2, e3; // random enables
    logic [1:0] ctl; // random control
    pieb_flags_t fv; // random flags
    int miscompares, n_tests;
    // free-running clock, 4 ns period
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // the single slave's hreadyout is the bus hready
    always_comb
    begin
        ar = req;
        ar.hready = rsp.hreadyout;
    end
    pieb_top uut (.clk(clk), .rst(rst), .ahb_req(ar), .hwdata(hwdata),
        .ahb_rsp(rsp), .src_flags(flags), .periph_irq_req(preq),
        .periph_irq_gated(gated), .irq(irq));
    pieb_src_model src (.clk(clk), .rst(rst), .set(fset), .clr(fclr),
        .flags(flags));
    // verdict and end of run
    task automatic final_report;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // sample at the falling edge, where data settle, then take the edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            rd_s = rsp.hrdata;
            rdy = rsp.hreadyout;
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        if (rdy !== 1'b1)
        begin
            miscompares++;
            $display("[ERR] %0t bus hang", $time);
            final_report();
        end
    endtask
    // one single word transfer; entered and left just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        req.hsel <= 1'b1;
        req.haddr <= {24'h0, a};
        req.htrans <= PIEB_HTRANS_NONSEQ;
        req.hwrite <= w;
        req.hsize <= 3'h2;
        wait_rdy();
        req.htrans <= 2'h0;
        req.hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        q = rd_s;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e)
        `CHK(rsp.hresp, 1'b0)
    endtask
    // irq comes from flops: look mid-cycle, not on its launching edge
    task automatic irq_chk(input logic e);
        @(negedge clk);
        `CHK(irq, e)
        @(posedge clk);
    endtask
    // drive the flag model to exactly v; settles one edge later
    task automatic put_flags(input pieb_flags_t v);
        fset <= v;
        fclr <= ~v;
        @(posedge clk);
        fset <= '0;
        fclr <= '0;
        @(posedge clk);
    endtask
    // expected {combined request, gated vector}
    function automatic logic [24:0] exp_gate(input pieb_flags_t f,
        input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
        input logic [1:0] m);
        logic [23:0] g;
        g = {f.bank3 & c & PIEB_IMPL_3, f.bank2 & b & PIEB_IMPL_2,
            f.bank1 & a & PIEB_IMPL_1};
        return {(|g) & (m[PIEB_CTL_GLOBAL] | m[PIEB_CTL_PRIO]), g};
    endfunction
    task automatic gate_chk;
        @(negedge clk);
        `CHK({preq, gated}, exp_gate(flags, e1, e2, e3, ctl))
        @(posedge clk);
    endtask
    initial
    begin
        rst = 1'b1;
        req = '0;
        hwdata = 32'h0;
        fset = '0;
        fclr = '0;
        miscompares = 0;
        n_tests = 0;
        void'($urandom(32'h1AC8));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // every register starts at zero
        for (int i = 0; i < 7; i++)
            rd_chk(8'(4 * i), 32'h0);
        $display("test reset done");
        // ones everywhere read back only implemented bits
        wr(PIEB_OFS_ENABLE_1, 32'hFFFF_FFFF);
        wr(PIEB_OFS_ENABLE_2, 32'hFFFF_FFFF);
        wr(PIEB_OFS_ENABLE_3, 32'hFFFF_FFFF);
        wr(8'h40, 32'hFFFF_FFFF);
        rd_chk(PIEB_OFS_ENABLE_1, {24'h0, PIEB_IMPL_1});
        rd_chk(PIEB_OFS_ENABLE_2, {24'h0, PIEB_IMPL_2});
        rd_chk(PIEB_OFS_ENABLE_3, {24'h0, PIEB_IMPL_3});
        rd_chk(8'h40, 32'h0);
        $display("test readback done");
        // a flag held while disabled comes through once enabled
        e1 = 8'h00;
        e2 = 8'h00;
        e3 = 8'h00;
        ctl = 2'h1;
        wr(PIEB_OFS_ENABLE_1, 32'h0);
        wr(PIEB_OFS_ENABLE_2, 32'h0);
        wr(PIEB_OFS_ENABLE_3, 32'h0);
        wr(PIEB_OFS_CONTROL, 32'h1);
        put_flags(24'h00_8040);
        gate_chk();
        e2 = 8'h80;
        wr(PIEB_OFS_ENABLE_2, 32'h80);
        gate_chk();
        `CHK(gated[15], 1'b1)
        $display("test held flag done");
        // random enables, flags and every control mode
        for (int i = 0; i < 24; i++)
        begin
            e1 = 8'($urandom);
            e2 = 8'($urandom);
            e3 = 8'($urandom);
            ctl = 2'(i);
            fv = 24'($urandom);
            wr(PIEB_OFS_ENABLE_1, {24'h0, e1});
            wr(PIEB_OFS_ENABLE_2, {24'h0, e2});
            wr(PIEB_OFS_ENABLE_3, {24'h0, e3});
            wr(PIEB_OFS_CONTROL, {30'h0, ctl});
            put_flags(fv);
            gate_chk();
            rd_chk(PIEB_OFS_ENABLE_1, {24'h0, e1 & PIEB_IMPL_1});
            rd_chk(PIEB_OFS_CONTROL, {30'h0, ctl});
        end
        $display("test random done");
        // event status: rise and fall of the request, mask, clear
        e1 = 8'h01;
        ctl = 2'h1;
        wr(PIEB_OFS_ENABLE_1, 32'h1);
        wr(PIEB_OFS_CONTROL, 32'h1);
        put_flags(24'h0);
        wr(PIEB_OFS_STATUS, 32'h3);
        wr(PIEB_OFS_MASK, 32'h3);
        rd_chk(PIEB_OFS_MASK, 32'h3);
        put_flags(24'h1);
        rd_chk(PIEB_OFS_STATUS, 32'h1);
        rd_chk(PIEB_OFS_REQ, 32'h1);
        irq_chk(1'b1);
        wr(PIEB_OFS_STATUS, 32'h1);
        rd_chk(PIEB_OFS_STATUS, 32'h0);
        irq_chk(1'b0);
        put_flags(24'h0);
        rd_chk(PIEB_OFS_STATUS, 32'h2);
        irq_chk(1'b1);
        wr(PIEB_OFS_MASK, 32'h0);
        irq_chk(1'b0);
        wr(PIEB_OFS_STATUS, 32'h2);
        rd_chk(PIEB_OFS_STATUS, 32'h0);
        $display("test events done");
        final_report();
    end
endmodule
`default_nettype wire
